// [inc/wdls_pkg.sv]
package wdls_pkg;

  // register map, byte addresses on the plain register port
  localparam int unsigned     ADDR_W     = 8;
  localparam int unsigned     DATA_W     = 32;
  localparam logic [7:0]      OFS_RELOAD = 8'h00;
  localparam logic [7:0]      OFS_VALUE  = 8'h04;
  localparam logic [7:0]      OFS_CTRL   = 8'h08;
  localparam logic [7:0]      OFS_CLEAR  = 8'h0C;
  localparam logic [7:0]      OFS_STATUS = 8'h10;
  localparam logic [7:0]      OFS_LOCK   = 8'h14;
  localparam logic [7:0]      OFS_EVT    = 8'h18;
  localparam logic [7:0]      OFS_EMASK  = 8'h1C;

  // access keys
  localparam logic [31:0]     KEY_FIRST  = 32'h1ACCE551;
  localparam logic [31:0]     KEY_SECOND = 32'hE5331AAE;

  // lock register read values
  localparam logic [31:0]     LOCK_RD_LOCKED = 32'h00000001;
  localparam logic [31:0]     LOCK_RD_OPEN   = 32'h00000000;

  // control fields
  localparam int unsigned     CTL_W          = 2;
  localparam int unsigned     CTL_IRQEN_BIT  = 0;
  localparam int unsigned     CTL_RSTEN_BIT  = 1;
  localparam logic [1:0]      CTL_RST        = 2'h3;

  // status field
  localparam int unsigned     STAT_FLAG_BIT  = 0;
  localparam logic [6:0]      STAT_UPPER     = 7'h00;

  // clear port width
  localparam int unsigned     CLR_W          = 8;
  localparam logic [7:0]      CLR_BYTE_RST   = 8'h00;

  // event status and mask
  localparam int unsigned     EVT_W          = 3;
  localparam int unsigned     EVT_EXPIRE     = 0;
  localparam int unsigned     EVT_BADKEY     = 1;
  localparam int unsigned     EVT_BADCLR     = 2;
  localparam logic [2:0]      EVT_RST        = 3'h0;
  localparam logic [2:0]      EMASK_RST      = 3'h0;

  // counter reload default
  localparam logic [31:0]     RELOAD_RST     = 32'h0000FFFF;
  localparam logic [31:0]     RDATA_RST      = 32'h00000000;

  typedef enum logic [1:0] {
    WDLS_LOCKED,
    WDLS_PART,
    WDLS_OPEN
  } wdls_lock_e;

endpackage : wdls_pkg

// [verilog/wdls_count.sv]
`timescale 1ns/10ps
`default_nettype none

module wdls_count
  import wdls_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  // control
  input  wire logic             run,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  // state
  output logic      [WIDTH-1:0] count,
  output logic                  expire
);

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic             at_zero;

  assign at_zero = (count_r == '0);
  // a load in the same cycle takes priority over expiry
  assign expire  = run & at_zero & ~load;
  assign count   = count_r;

  assign count_nxt = load    ? load_val :
                     expire  ? load_val :
                     run     ? count_r - 1'b1 :
                               count_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= WIDTH'(RELOAD_RST);
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule : wdls_count

`default_nettype wire

// [verilog/wdls_lock_status.sv]
// Behaviour
// R1: status bit 0 reads one while a watchdog interrupt is pending
// R2: status bits 7:1 always read zero; software writes zeros there
// R3: status register writes change nothing
// R4: only power-on reset initialises status and lock
// R5: first key unlocks every register except control
// R6: second key directly after the first unlocks control too
// R7: any other lock write or value relocks everything; event status and mask writes are never locked
// R8: lock reads zero when unlocked, one when locked
// R9: locked registers stay readable; writes to them are dropped
// R10: clear happens only when second byte is inverse of the first
// R11: every finished clear sequence relocks, good or bad
// R12: interrupt handlers write the lock register first to unlock
// R13: writing zero to the enable bit clears the status flag
// R14: rewriting the reload value clears a pending interrupt
// R15: good clear drops the interrupt and reloads the counter
// R16: after power-on, locked and waiting for the first key
// R17: clear tracker keeps the first byte and compares its inverse
`timescale 1ns/10ps
`default_nettype none

module wdls_lock_status
  import wdls_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // watchdog outputs
  output logic                   wdog_irq,
  output logic                   wdog_rst_req,
  // event interrupt
  output logic                   evt_irq,
  // lock state
  output logic                   regs_locked,
  output logic                   ctrl_writable
);

  function automatic logic hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction : hit

  // state registers
  wdls_lock_e        lock_r;
  wdls_lock_e        lock_nxt;
  logic              clr_armed_r;
  logic              clr_armed_nxt;
  logic [CLR_W-1:0]  clr_byte_r;
  logic [CLR_W-1:0]  clr_byte_nxt;
  logic [CTL_W-1:0]  ctl_r;
  logic [CTL_W-1:0]  ctl_nxt;
  logic [CNT_W-1:0]  reload_r;
  logic [CNT_W-1:0]  reload_nxt;
  logic              flag_r;
  logic              flag_nxt;
  logic              rst_req_r;
  logic              rst_req_nxt;
  logic [EVT_W-1:0]  evt_r;
  logic [EVT_W-1:0]  evt_nxt;
  logic [EVT_W-1:0]  emask_r;
  logic [EVT_W-1:0]  emask_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // address decode
  logic wr_reload;
  logic wr_ctrl;
  logic wr_clear;
  logic wr_lock;
  logic wr_evt;
  logic wr_emask;

  assign wr_reload = reg_wr & hit(reg_addr, OFS_RELOAD);
  assign wr_ctrl   = reg_wr & hit(reg_addr, OFS_CTRL);
  assign wr_clear  = reg_wr & hit(reg_addr, OFS_CLEAR);
  assign wr_lock   = reg_wr & hit(reg_addr, OFS_LOCK);
  assign wr_evt    = reg_wr & hit(reg_addr, OFS_EVT);
  assign wr_emask  = reg_wr & hit(reg_addr, OFS_EMASK);

  // lock qualification
  logic unlocked;
  logic ctl_open;
  logic wr_reload_ok;
  logic wr_ctrl_ok;
  logic wr_clear_ok;

  assign unlocked     = (lock_r != WDLS_LOCKED);
  assign ctl_open     = (lock_r == WDLS_OPEN);
  // R9: writes dropped while locked
  assign wr_reload_ok = wr_reload & unlocked;
  // R5: control stays shut after the first key alone
  assign wr_ctrl_ok   = wr_ctrl & ctl_open;
  assign wr_clear_ok  = wr_clear & unlocked;

  // clear sequence
  logic [CLR_W-1:0] clr_data;
  logic             clr_first;
  logic             clr_second;
  logic             clr_match;

  assign clr_data   = reg_wdata[CLR_W-1:0];
  assign clr_first  = wr_clear_ok & ~clr_armed_r;
  assign clr_second = wr_clear_ok & clr_armed_r;
  // R10: R17: compare with inverse of stored byte
  assign clr_match  = clr_second & (clr_data == ~clr_byte_r);

  // lock sequencer
  logic bad_key;

  always_comb begin
    lock_nxt = lock_r;
    bad_key  = 1'b0;
    if (wr_lock) begin
      if (reg_wdata == KEY_FIRST && lock_r != WDLS_PART) begin
        // R5: first key
        lock_nxt = WDLS_PART;
      end else if (reg_wdata == KEY_SECOND && lock_r == WDLS_PART) begin
        // R6: inverse key right after first
        lock_nxt = WDLS_OPEN;
      end else begin
        // R7: wrong order or value
        lock_nxt = WDLS_LOCKED;
        bad_key  = 1'b1;
      end
    end else if (clr_second) begin
      // R11: relock after clear sequence
      lock_nxt = WDLS_LOCKED;
    end
  end

  // R17: tracker dropped whenever the block relocks
  assign clr_armed_nxt = (lock_nxt == WDLS_LOCKED) ? 1'b0 :
                         clr_first                 ? 1'b1 :
                                                     clr_armed_r;
  assign clr_byte_nxt  = clr_first ? clr_data : clr_byte_r;

  // control register
  logic irq_en;
  logic rst_en;
  logic irq_en_rise;

  assign irq_en      = ctl_r[CTL_IRQEN_BIT];
  assign rst_en      = ctl_r[CTL_RSTEN_BIT];
  assign ctl_nxt     = wr_ctrl_ok ? reg_wdata[CTL_W-1:0] : ctl_r;
  // restart reloads the counter
  assign irq_en_rise = wr_ctrl_ok & reg_wdata[CTL_IRQEN_BIT] & ~irq_en;

  assign reload_nxt  = wr_reload_ok ? reg_wdata[CNT_W-1:0] : reload_r;

  // counter
  logic             cnt_load;
  logic [CNT_W-1:0] cnt_load_val;
  logic [CNT_W-1:0] cnt_value;
  logic             expire;

  // R15: good clear reloads the counter
  assign cnt_load     = wr_reload_ok | clr_match | irq_en_rise;
  assign cnt_load_val = wr_reload_ok ? reg_wdata[CNT_W-1:0] : reload_r;

  wdls_count #(
    .WIDTH    (CNT_W)
  ) u_count (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .run      (irq_en),
    .load     (cnt_load),
    .load_val (cnt_load_val),
    .count    (cnt_value),
    .expire   (expire)
  );

  // interrupt flag
  logic flag_clr;

  // R13: R14: R15: hardware clearing paths
  assign flag_clr = (wr_ctrl_ok & ~reg_wdata[CTL_IRQEN_BIT]) |
                    wr_reload_ok |
                    clr_match;
  // R1: R3: expiry sets, set beats clear
  assign flag_nxt = expire | (flag_r & ~flag_clr);

  // second expiry with a pending flag asks for reset
  assign rst_req_nxt = expire & flag_r & rst_en;

  // event status, write one to clear
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_wclr;

  assign evt_set[EVT_EXPIRE] = expire;
  assign evt_set[EVT_BADKEY] = bad_key;
  assign evt_set[EVT_BADCLR] = clr_second & ~clr_match;
  assign evt_wclr  = wr_evt ? reg_wdata[EVT_W-1:0] : EVT_RST;
  assign emask_nxt = wr_emask ? reg_wdata[EVT_W-1:0] : emask_r;

  genvar gi;
  generate
    for (gi = 0; gi < EVT_W; gi++) begin : g_evt
      assign evt_nxt[gi] = evt_set[gi] | (evt_r[gi] & ~evt_wclr[gi]);
    end
  endgenerate

  // read mux
  logic [DATA_W-1:0] rd_status;
  logic [DATA_W-1:0] rd_lock;
  logic [DATA_W-1:0] rd_mux;

  // R1: R2: flag in bit 0, upper bits zero
  assign rd_status = {{(DATA_W-8){1'b0}}, STAT_UPPER, flag_r};
  // R8: lock read value
  assign rd_lock   = (lock_r == WDLS_LOCKED) ? LOCK_RD_LOCKED : LOCK_RD_OPEN;

  // R9: reads ignore the lock
  assign rd_mux =
    hit(reg_addr, OFS_RELOAD) ? DATA_W'(reload_r) :
    hit(reg_addr, OFS_VALUE)  ? DATA_W'(cnt_value) :
    hit(reg_addr, OFS_CTRL)   ? DATA_W'(ctl_r) :
    hit(reg_addr, OFS_STATUS) ? rd_status :
    hit(reg_addr, OFS_LOCK)   ? rd_lock :
    hit(reg_addr, OFS_EVT)    ? DATA_W'(evt_r) :
    hit(reg_addr, OFS_EMASK)  ? DATA_W'(emask_r) :
                                RDATA_RST;

  // data stands only in the cycle after the strobe
  assign rdata_nxt = reg_rd ? rd_mux : RDATA_RST;

  // R4: R16: power-on reset only, locked and idle
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_r <= WDLS_LOCKED;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      clr_armed_r <= 1'b0;
      clr_byte_r  <= CLR_BYTE_RST;
    end else begin
      clr_armed_r <= clr_armed_nxt;
      clr_byte_r  <= clr_byte_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_r    <= CTL_RST;
      reload_r <= CNT_W'(RELOAD_RST);
    end else begin
      ctl_r    <= ctl_nxt;
      reload_r <= reload_nxt;
    end
  end

  // R4: flag initialised only by power-on reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_r    <= 1'b0;
      rst_req_r <= 1'b0;
    end else begin
      flag_r    <= flag_nxt;
      rst_req_r <= rst_req_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      evt_r   <= EVT_RST;
      emask_r <= EMASK_RST;
    end else begin
      evt_r   <= evt_nxt;
      emask_r <= emask_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= RDATA_RST;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // outputs
  assign reg_rdata     = rdata_r;
  assign wdog_irq      = flag_r;
  assign wdog_rst_req  = rst_req_r;
  assign evt_irq       = |(evt_r & emask_r);
  assign regs_locked   = ~unlocked;
  assign ctrl_writable = ctl_open;

endmodule : wdls_lock_status

`default_nettype wire

// [test/wdls_lock_status_chk.sv]
`timescale 1ns/10ps
`default_nettype none

module wdls_lock_status_chk
  import wdls_pkg::*;
#(
  parameter int unsigned CNT_W = 32
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_b,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  // watchdog and lock state
  input wire logic              wdog_irq,
  input wire logic              wdog_rst_req,
  input wire logic              evt_irq,
  input wire logic              regs_locked,
  input wire logic              ctrl_writable
);
  wire lock_wr = reg_wr && reg_addr == OFS_LOCK;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  lock_read_a: assert property (reg_rd && reg_addr == OFS_LOCK |=>
    reg_rdata == ($past(regs_locked) ? LOCK_RD_LOCKED : LOCK_RD_OPEN))
    else $error("lock register read value off");
  status_read_a: assert property (reg_rd && reg_addr == OFS_STATUS |=>
    reg_rdata == {31'h00000000, $past(wdog_irq)})
    else $error("status read does not match flag");
  upper_zero_a: assert property ($past(reg_rd) &&
    $past(reg_addr) == OFS_STATUS |-> reg_rdata[7:1] == STAT_UPPER)
    else $error("status upper bits not zero");
  first_key_a: assert property (lock_wr && reg_wdata == KEY_FIRST &&
    regs_locked |=> !regs_locked && !ctrl_writable)
    else $error("first key did not open partially");
  second_key_a: assert property (lock_wr && reg_wdata == KEY_SECOND &&
    !regs_locked && !ctrl_writable |=> ctrl_writable)
    else $error("second key did not open control");
  bad_key_a: assert property (lock_wr && reg_wdata != KEY_FIRST &&
    reg_wdata != KEY_SECOND |=> regs_locked && !ctrl_writable)
    else $error("bad lock write left registers open");
  status_wr_a: assert property (reg_wr && reg_addr == OFS_STATUS &&
    wdog_irq |=> wdog_irq)
    else $error("status write changed the flag");
  ctrl_off_a: assert property (reg_wr && reg_addr == OFS_CTRL &&
    ctrl_writable && !reg_wdata[CTL_IRQEN_BIT] |=> !wdog_irq)
    else $error("disabling did not clear the flag");
  lock_state_a: assert property (regs_locked |-> !ctrl_writable)
    else $error("control writable while locked");
  // locked and idle right after power-on
  reset_locked_a: assert property ($rose(rst_b) |->
    regs_locked && !ctrl_writable && !wdog_irq && !wdog_rst_req)
    else $error("not locked and idle after power-on");
  // reset request only with a pending flag
  rst_req_flag_a: assert property (wdog_rst_req |-> wdog_irq)
    else $error("reset request without pending flag");
endmodule : wdls_lock_status_chk

bind wdls_lock_status wdls_lock_status_chk #(.CNT_W(CNT_W))
  i_wdls_lock_status_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .wdog_irq(wdog_irq), .wdog_rst_req(wdog_rst_req),
  .evt_irq(evt_irq), .regs_locked(regs_locked),
  .ctrl_writable(ctrl_writable));

`default_nettype wire

// [test/test_watchdog_lock_and_status.sv]
`timescale 1ns/10ps
`default_nettype none

module test_watchdog_lock_and_status
  import wdls_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst_b   = 1'b0;
  logic [ADDR_W-1:0] reg_addr  = 8'h00;
  logic [DATA_W-1:0] reg_wdata = 32'h00000000;
  logic              reg_wr  = 1'b0;
  logic              reg_rd  = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              wdog_irq;
  logic              wdog_rst_req;
  logic              evt_irq;
  logic              regs_locked;
  logic              ctrl_writable;
  int                n_fail  = 0;
  int                checked = 0;

  always #10 sys_clk = ~sys_clk;

  wdls_lock_status #(.CNT_W(32)) i_wdls_lock_status (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wdog_irq(wdog_irq),
    .wdog_rst_req(wdog_rst_req), .evt_irq(evt_irq),
    .regs_locked(regs_locked), .ctrl_writable(ctrl_writable));

  task automatic give_verdict;
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      n_fail++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd

  task automatic unlock(input logic full);
    wr(OFS_LOCK, 32'h00000000);
    wr(OFS_LOCK, KEY_FIRST);
    if (full) begin
      wr(OFS_LOCK, KEY_SECOND);
    end
  endtask : unlock

  task automatic wait_irq;
    int i;
    for (i = 0; i < 200 && wdog_irq !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    if (wdog_irq !== 1'b1) begin
      $display("wrong value at %0t: no watchdog interrupt", $time);
      n_fail++;
      give_verdict();
    end
  endtask : wait_irq

  task automatic t_reset;
    chk({31'h00000000, regs_locked}, 32'h00000001);
    chk({31'h00000000, ctrl_writable}, 32'h00000000);
    rd(OFS_LOCK, LOCK_RD_LOCKED);
    rd(OFS_STATUS, 32'h00000000);
    rd(OFS_RELOAD, RELOAD_RST);
    rd(OFS_CTRL, 32'h00000003);
  endtask : t_reset

  task automatic t_lock;
    unlock(1'b0);
    rd(OFS_LOCK, LOCK_RD_OPEN);
    wr(OFS_CTRL, 32'h00000000);
    rd(OFS_CTRL, 32'h00000003);
    wr(OFS_LOCK, KEY_SECOND);
    chk({31'h00000000, ctrl_writable}, 32'h00000001);
    wr(OFS_LOCK, 32'h12345678);
    chk({31'h00000000, regs_locked}, 32'h00000001);
    wr(OFS_RELOAD, 32'h00000010);
    rd(OFS_RELOAD, RELOAD_RST);
    wr(OFS_LOCK, KEY_SECOND);
    chk({31'h00000000, regs_locked}, 32'h00000001);
  endtask : t_lock

  // event status, mask and clear
  task automatic t_evt;
    wr(OFS_EVT, 32'h00000007);
    wr(OFS_EMASK, 32'h00000002);
    chk({31'h00000000, evt_irq}, 32'h00000000);
    wr(OFS_LOCK, 32'h0000ABCD);
    chk({31'h00000000, evt_irq}, 32'h00000001);
    rd(OFS_EVT, 32'h00000002);
    wr(OFS_EMASK, 32'h00000000);
    chk({31'h00000000, evt_irq}, 32'h00000000);
    wr(OFS_EMASK, 32'h00000002);
    wr(OFS_EVT, 32'h00000002);
    chk({31'h00000000, evt_irq}, 32'h00000000);
    rd(OFS_EVT, 32'h00000000);
    rd(8'h3C, 32'h00000000);
  endtask : t_evt

  task automatic t_expire;
    unlock(1'b0);
    wr(OFS_RELOAD, 32'h00000020);
    chk({31'h00000000, wdog_irq}, 32'h00000000);
    wait_irq();
    rd(OFS_STATUS, 32'h00000001);
    wr(OFS_STATUS, 32'h00000000);
    rd(OFS_STATUS, 32'h00000001);
    unlock(1'b0);
    wr(OFS_RELOAD, 32'h00000020);
    chk({31'h00000000, wdog_irq}, 32'h00000000);
  endtask : t_expire

  task automatic t_clear;
    int i;
    wait_irq();
    unlock(1'b0);
    wr(OFS_CLEAR, 32'h0000005A);
    wr(OFS_CLEAR, 32'h000000A5);
    chk({31'h00000000, wdog_irq}, 32'h00000000);
    chk({31'h00000000, regs_locked}, 32'h00000001);
    wait_irq();
    unlock(1'b0);
    wr(OFS_CLEAR, 32'h0000005A);
    wr(OFS_CLEAR, 32'h0000005B);
    chk({31'h00000000, wdog_irq}, 32'h00000001);
    chk({31'h00000000, regs_locked}, 32'h00000001);
    // flag still pending, next expiry asks for reset
    for (i = 0; i < 200 && wdog_rst_req !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({31'h00000000, wdog_rst_req}, 32'h00000001);
    @(posedge sys_clk);
    #1;
    chk({31'h00000000, wdog_rst_req}, 32'h00000000);
  endtask : t_clear

  task automatic t_ctrl;
    unlock(1'b1);
    chk({31'h00000000, ctrl_writable}, 32'h00000001);
    wr(OFS_CTRL, 32'h00000002);
    chk({31'h00000000, wdog_irq}, 32'h00000000);
    rd(OFS_CTRL, 32'h00000002);
    wr(OFS_CTRL, 32'h00000003);
  endtask : t_ctrl

  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    #1;
    t_reset();
    t_lock();
    t_evt();
    t_expire();
    t_clear();
    t_ctrl();
    give_verdict();
  end
endmodule : test_watchdog_lock_and_status

`default_nettype wire
